// file: verilog/utc_pkg.sv
// Constants, register map and types shared by the transceiver control register bank
package utc_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_XCVR_CTRL = 9'h100;
    localparam logic [ADDR_W-1:0] OFS_OBSERVE   = 9'h104;
    localparam logic [ADDR_W-1:0] OFS_PULLUP    = 9'h108;
    localparam logic [ADDR_W-1:0] OFS_WAKE_RST  = 9'h10c;
    localparam logic [ADDR_W-1:0] OFS_EVT_STAT  = 9'h110;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 9'h114;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_SUSPEND    = 7;
    localparam int BIT_PULLDOWN   = 6;
    localparam int BIT_OBS_DP_UP  = 7;
    localparam int BIT_OBS_DP_DN  = 6;
    localparam int BIT_OBS_DM_DN  = 4;
    localparam int BIT_PLAIN_PU   = 4;
    localparam int BIT_SOFT_RST   = 7;
    localparam int BIT_MUST_ONE   = 6;
    localparam int BIT_WAKE_EN    = 5;
    localparam int BIT_SYNC_SEEN  = 1;
    localparam int BIT_RESUME_INT = 0;

    // Event status / mask layout
    localparam int EVT_W      = 2;
    localparam int EVT_RESUME = 0;
    localparam int EVT_SYNC   = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic               RST_BIT  = 1'b0;
    localparam logic [EVT_W-1:0]   RST_EVT  = 2'h0;
    localparam logic [DATA_W-1:0]  RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing: module soft reset held for two module clock cycles
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 20;
    localparam logic [1:0]  SOFT_RST_CYC  = 2'h2;
    localparam logic [1:0]  CNT_ZERO      = 2'h0;
    localparam logic [1:0]  CNT_ONE       = 2'h1;

    // Bus handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } utc_bus_e;

endpackage : utc_pkg

// file: verilog/utc_sticky_flag.sv
// Sticky detection flag: set wins over clear, cleared by module reset
`timescale 1ns/10ps
module utc_sticky_flag
    import utc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic mrst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o,
    output logic      rise_o
);

    logic flag_q;
    logic flag_d;

    // Next value, set beats clear
    always_comb begin
        flag_d = set_i | (flag_q & ~clr_i);
    end

    always_ff @(posedge clock_i) begin
        if (mrst_i) begin
            flag_q <= RST_BIT;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
    assign rise_o = set_i & ~flag_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_flag_set;
        @(posedge clock_i) disable iff (mrst_i)
        set_i |=> flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set after set request");

    property p_flag_hold;
        @(posedge clock_i) disable iff (mrst_i)
        (flag_o && !clr_i) |=> flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped without clear");

endmodule // utc_sticky_flag

// file: verilog/utc_soft_reset.sv
// Self-timed module soft reset pulse generator
`timescale 1ns/10ps
module utc_soft_reset
    import utc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic srst_i,
    input  wire logic req_i,
    output logic      rst_o
);

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       rst_q;
    logic       rst_d;

    // Load the hold count on request, then count down
    always_comb begin
        if (req_i) begin
            cnt_d = SOFT_RST_CYC;
        end else if (cnt_q != CNT_ZERO) begin
            cnt_d = cnt_q - CNT_ONE;
        end else begin
            cnt_d = CNT_ZERO;
        end
        rst_d = (cnt_d != CNT_ZERO);
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cnt_q <= CNT_ZERO;
            rst_q <= RST_BIT;
        end else begin
            cnt_q <= cnt_d;
            rst_q <= rst_d;
        end
    end

    assign rst_o = rst_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_rst_req;
        req_i && !rst_o;
    endsequence

    sequence s_rst_pulse;
        rst_o [*2] ##1 !rst_o;
    endsequence

    property p_soft_rst_pulse;
        @(posedge clock_i) disable iff (srst_i)
        s_rst_req |=> s_rst_pulse;
    endproperty
    a_soft_rst_pulse: assert property (p_soft_rst_pulse)
        else $error("soft reset pulse not two cycles then released");

endmodule // utc_soft_reset

// file: verilog/utc_xcvr_regs.sv
// Transceiver control register bank with Avalon-MM slave and event interrupt
`timescale 1ns/10ps

module utc_xcvr_regs
    import utc_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    input  wire logic [ADDR_W-1:0] avm_address_i,
    input  wire logic              avm_read_i,
    input  wire logic              avm_write_i,
    input  wire logic [DATA_W-1:0] avm_writedata_i,
    output logic      [DATA_W-1:0] avm_readdata_o,
    output logic                   avm_waitrequest_o,
    input  wire logic              host_mode_i,
    input  wire logic              otg_mode_i,
    input  wire logic              sync_irq_i,
    input  wire logic              dp_raw_i,
    input  wire logic              dm_raw_i,
    output logic                   xcvr_suspend_o,
    output logic                   dplus_pullup_o,
    output logic                   dplus_pulldown_o,
    output logic                   dminus_pulldown_o,
    output logic                   module_reset_o,
    output logic                   wake_event_o,
    output logic                   irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    utc_bus_e          state_q;
    utc_bus_e          state_d;
    logic              wait_q;
    logic              wait_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    logic              suspend_q;
    logic              suspend_d;
    logic              pulldown_q;
    logic              pulldown_d;
    logic              plain_pu_q;
    logic              plain_pu_d;
    logic              must_one_q;
    logic              must_one_d;
    logic              wake_en_q;
    logic              wake_en_d;
    logic [EVT_W-1:0]  mask_q;
    logic [EVT_W-1:0]  mask_d;
    logic [EVT_W-1:0]  stat_q;
    logic [EVT_W-1:0]  stat_d;

    logic              pu_q;
    logic              pu_d;
    logic              pd_q;
    logic              pd_d;
    logic              irq_q;
    logic              irq_d;

    logic              mrst;
    logic              acc;
    logic              wr_acc;
    logic              rd_acc;
    logic              soft_req;
    logic              kstate;
    logic              resume_set;
    logic              resume_clr;
    logic              resume_flag;
    logic              resume_rise;
    logic              sync_clr;
    logic              sync_flag;
    logic              sync_rise;
    logic [EVT_W-1:0]  evt_set;
    logic [EVT_W-1:0]  evt_clr;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address match against one register offset
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] ofs);
        addr_is = (a == ofs);
    endfunction

    // Read word assembly, reserved bits zero
    function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = RST_WORD;
        if (addr_is(a, OFS_XCVR_CTRL)) begin
            w[BIT_SUSPEND]  = suspend_q;
            w[BIT_PULLDOWN] = pulldown_q;
        end else if (addr_is(a, OFS_OBSERVE)) begin
            w[BIT_OBS_DP_UP] = pu_q;
            w[BIT_OBS_DP_DN] = pd_q;
            w[BIT_OBS_DM_DN] = pd_q;
        end else if (addr_is(a, OFS_PULLUP)) begin
            w[BIT_PLAIN_PU] = plain_pu_q;
        end else if (addr_is(a, OFS_WAKE_RST)) begin
            // Soft reset bit is never stored, so it reads zero
            w[BIT_MUST_ONE]   = must_one_q;
            w[BIT_WAKE_EN]    = wake_en_q;
            w[BIT_SYNC_SEEN]  = sync_flag;
            w[BIT_RESUME_INT] = resume_flag;
        end else if (addr_is(a, OFS_EVT_STAT)) begin
            w[EVT_W-1:0] = stat_q;
        end else if (addr_is(a, OFS_EVT_MASK)) begin
            w[EVT_W-1:0] = mask_q;
        end
        read_word = w;
    endfunction

    // ------------------------------------------------------------------
    // Bus handshake: one wait cycle, then one acknowledge cycle
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        case (state_q)
            BUS_IDLE: begin
                if (avm_read_i || avm_write_i) begin
                    state_d = BUS_ACK;
                    wait_d  = 1'b0;
                    rdata_d = avm_read_i ? read_word(avm_address_i) : RST_WORD;
                end
            end
            BUS_ACK: begin
                state_d = BUS_IDLE;
            end
            default: begin
                state_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_q <= BUS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= RST_WORD;
        end else begin
            state_q <= state_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // Access completes at the edge where waitrequest is low
    assign acc      = (state_q == BUS_ACK);
    assign wr_acc   = acc & avm_write_i;
    assign rd_acc   = acc & avm_read_i;
    assign soft_req = wr_acc & addr_is(avm_address_i, OFS_WAKE_RST)
                      & avm_writedata_i[BIT_SOFT_RST];

    // ------------------------------------------------------------------
    // Soft reset and module reset
    // ------------------------------------------------------------------
    utc_soft_reset u_soft_reset (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .req_i   (soft_req),
        .rst_o   (module_reset_o)
    );

    assign mrst = srst_i | module_reset_o;

    // ------------------------------------------------------------------
    // Detection flags
    // ------------------------------------------------------------------
    // Full-speed K-state on the raw pins, no filter
    assign kstate     = ~dp_raw_i & dm_raw_i;
    assign resume_set = wake_en_q & ~host_mode_i & kstate;
    assign resume_clr = ~wake_en_q & ~kstate;
    assign sync_clr   = ~sync_irq_i & rd_acc & addr_is(avm_address_i, OFS_WAKE_RST);

    utc_sticky_flag u_resume_flag (
        .clock_i (clock_i),
        .mrst_i  (mrst),
        .set_i   (resume_set),
        .clr_i   (resume_clr),
        .flag_o  (resume_flag),
        .rise_o  (resume_rise)
    );

    utc_sticky_flag u_sync_flag (
        .clock_i (clock_i),
        .mrst_i  (mrst),
        .set_i   (sync_irq_i),
        .clr_i   (sync_clr),
        .flag_o  (sync_flag),
        .rise_o  (sync_rise)
    );

    // ------------------------------------------------------------------
    // Control registers, event status and derived outputs
    // ------------------------------------------------------------------
    always_comb begin
        suspend_d  = suspend_q;
        pulldown_d = pulldown_q;
        plain_pu_d = plain_pu_q;
        must_one_d = must_one_q;
        wake_en_d  = wake_en_q;
        mask_d     = mask_q;
        if (wr_acc) begin
            if (addr_is(avm_address_i, OFS_XCVR_CTRL)) begin
                suspend_d  = avm_writedata_i[BIT_SUSPEND];
                pulldown_d = avm_writedata_i[BIT_PULLDOWN];
            end
            if (addr_is(avm_address_i, OFS_PULLUP)) begin
                plain_pu_d = avm_writedata_i[BIT_PLAIN_PU];
            end
            if (addr_is(avm_address_i, OFS_WAKE_RST)) begin
                must_one_d = avm_writedata_i[BIT_MUST_ONE];
                wake_en_d  = avm_writedata_i[BIT_WAKE_EN];
            end
            if (addr_is(avm_address_i, OFS_EVT_MASK)) begin
                mask_d = avm_writedata_i[EVT_W-1:0];
            end
        end
        // Only bits already returned by the read are cleared; new sets win
        evt_set = {sync_rise, resume_rise};
        evt_clr = (rd_acc && addr_is(avm_address_i, OFS_EVT_STAT))
                  ? rdata_q[EVT_W-1:0] : RST_EVT;
        stat_d  = evt_set | (stat_q & ~evt_clr);
        // Pull-up only as a plain device, never host or OTG
        pu_d    = plain_pu_d & ~host_mode_i & ~otg_mode_i;
        pd_d    = pulldown_d;
        irq_d   = |(stat_d & mask_d);
    end

    always_ff @(posedge clock_i) begin
        if (mrst) begin
            suspend_q  <= RST_BIT;
            pulldown_q <= RST_BIT;
            plain_pu_q <= RST_BIT;
            must_one_q <= RST_BIT;
            wake_en_q  <= RST_BIT;
            mask_q     <= RST_EVT;
            stat_q     <= RST_EVT;
            pu_q       <= RST_BIT;
            pd_q       <= RST_BIT;
            irq_q      <= RST_BIT;
        end else begin
            suspend_q  <= suspend_d;
            pulldown_q <= pulldown_d;
            plain_pu_q <= plain_pu_d;
            must_one_q <= must_one_d;
            wake_en_q  <= wake_en_d;
            mask_q     <= mask_d;
            stat_q     <= stat_d;
            pu_q       <= pu_d;
            pd_q       <= pd_d;
            irq_q      <= irq_d;
        end
    end

    // Outputs straight from flops
    assign avm_readdata_o    = rdata_q;
    assign avm_waitrequest_o = wait_q;
    assign xcvr_suspend_o    = suspend_q;
    assign dplus_pullup_o    = pu_q;
    assign dplus_pulldown_o  = pd_q;
    assign dminus_pulldown_o = pd_q;
    assign wake_event_o      = resume_flag;
    assign irq_o             = irq_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (mrst);

    sequence s_wr(logic [ADDR_W-1:0] ofs);
        wr_acc && addr_is(avm_address_i, ofs);
    endsequence

    sequence s_rd_ack(logic [ADDR_W-1:0] ofs);
        acc && avm_read_i && addr_is(avm_address_i, ofs);
    endsequence

    property p_suspend_write;
        s_wr(OFS_XCVR_CTRL) |=> (xcvr_suspend_o == $past(avm_writedata_i[BIT_SUSPEND]));
    endproperty
    a_suspend_write: assert property (p_suspend_write)
        else $error("suspend output does not follow written bit");

    property p_pulldown_write;
        s_wr(OFS_XCVR_CTRL) |=> ##1 (dplus_pulldown_o == $past(avm_writedata_i[BIT_PULLDOWN], 2))
                                && (dminus_pulldown_o == dplus_pulldown_o);
    endproperty
    a_pulldown_write: assert property (p_pulldown_write)
        else $error("pull-downs do not follow written bit");

    property p_reserved_zero;
        s_rd_ack(OFS_OBSERVE) |-> (avm_readdata_o[DATA_W-1:8] == 24'h000000)
                                  && !avm_readdata_o[5] && (avm_readdata_o[3:0] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved observe bits not zero");

    property p_observe_live;
        s_rd_ack(OFS_OBSERVE) |-> (avm_readdata_o[BIT_OBS_DP_UP] == $past(dplus_pullup_o))
                                  && (avm_readdata_o[BIT_OBS_DM_DN] == $past(dminus_pulldown_o));
    endproperty
    a_observe_live: assert property (p_observe_live)
        else $error("observe register does not show live outputs");

    property p_pullup_mode;
        (host_mode_i || otg_mode_i) |=> !dplus_pullup_o;
    endproperty
    a_pullup_mode: assert property (p_pullup_mode)
        else $error("pull-up on outside plain device mode");

    property p_soft_bit_zero;
        s_rd_ack(OFS_WAKE_RST) |-> !avm_readdata_o[BIT_SOFT_RST] && !avm_readdata_o[4];
    endproperty
    a_soft_bit_zero: assert property (p_soft_bit_zero)
        else $error("soft reset bit read as one");

    property p_resume_wake;
        (wake_en_q && !host_mode_i && !dp_raw_i && dm_raw_i) |=> wake_event_o;
    endproperty
    a_resume_wake: assert property (p_resume_wake)
        else $error("no wake event on K-state");

    property p_host_no_wake;
        (host_mode_i && !wake_event_o) |=> !wake_event_o;
    endproperty
    a_host_no_wake: assert property (p_host_no_wake)
        else $error("wake event raised in host mode");

    property p_flags_read;
        s_rd_ack(OFS_WAKE_RST) |-> (avm_readdata_o[BIT_SYNC_SEEN] == $past(sync_flag))
                                   && (avm_readdata_o[BIT_RESUME_INT] == $past(resume_flag));
    endproperty
    a_flags_read: assert property (p_flags_read)
        else $error("detection flags misread");

endmodule // utc_xcvr_regs

// file: testbench/utc_cable_model.sv
// Behavioural cable side: drives raw D+/D- levels seen by the transceiver
`timescale 1ns/10ps
module utc_cable_model (
    input  wire logic clock_i,
    input  wire logic k_req_i,
    input  wire logic pullup_i,
    output logic      dp_o,
    output logic      dm_o
);
    // ------------------------------------------------------------
    // Line state
    // ------------------------------------------------------------
    // K-state on request, J when pulled up, otherwise SE0 by pull-downs
    initial begin
        dp_o = 1'b0;
        dm_o = 1'b0;
    end
    always @(posedge clock_i) begin
        dp_o <= !k_req_i && pullup_i;
        dm_o <= k_req_i;
    end
endmodule // utc_cable_model

// file: testbench/tb_usb_transceiver_control_regs.sv
// Self-checking testbench of the transceiver control register bank
`timescale 1ns/10ps
module tb_usb_transceiver_control_regs;
    import utc_pkg::*;
    logic              clock_i = 0, srst_i = 1, avm_read_i = 0, avm_write_i = 0;
    logic              host_mode_i = 0, otg_mode_i = 0, sync_irq_i = 0, k_req = 0;
    logic [ADDR_W-1:0] avm_address_i = '0;
    logic [DATA_W-1:0] avm_writedata_i = '0, avm_readdata_o, rd;
    logic              avm_waitrequest_o, dp, dm, suspended, pu, dpd, dmd, mrst, wake, irq;
    logic [7:0]        v;
    logic              e_pu, e_pd;
    integer            err_count = 0, checked = 0, seed = 6099, cyc = 0, i;

    utc_xcvr_regs utc_xcvr_regs_inst (.clock_i(clock_i), .srst_i(srst_i),
        .avm_address_i(avm_address_i), .avm_read_i(avm_read_i), .avm_write_i(avm_write_i),
        .avm_writedata_i(avm_writedata_i), .avm_readdata_o(avm_readdata_o),
        .avm_waitrequest_o(avm_waitrequest_o), .host_mode_i(host_mode_i),
        .otg_mode_i(otg_mode_i), .sync_irq_i(sync_irq_i), .dp_raw_i(dp), .dm_raw_i(dm),
        .xcvr_suspend_o(suspended), .dplus_pullup_o(pu), .dplus_pulldown_o(dpd),
        .dminus_pulldown_o(dmd), .module_reset_o(mrst), .wake_event_o(wake), .irq_o(irq));
    utc_cable_model utc_cable_model_inst (.clock_i(clock_i), .k_req_i(k_req),
        .pullup_i(pu), .dp_o(dp), .dm_o(dm));

    // ------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------
    always #10 clock_i = !clock_i;
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (cyc >= 20000) begin
            err_count = err_count + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One Avalon-MM access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        avm_write_i     <= w;
        avm_read_i      <= !w;
        avm_address_i   <= a;
        avm_writedata_i <= {24'h00_0000, d};
        do @(posedge clock_i); while (avm_waitrequest_o !== 1'b0);
        rd = avm_readdata_o;
        avm_write_i <= 1'b0;
        avm_read_i  <= 1'b0;
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, e});
    endtask
    function automatic logic [7:0] obs(input logic p, input logic d);
        return {p, d, 1'b0, d, 4'h0};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock_i);
        srst_i <= 1'b0;
        for (i = 0; i < 7; i = i + 1) rdchk(OFS_XCVR_CTRL + 9'(4 * i), 8'h00);
        // Suspend and pull-down bits, reserved bits stay zero
        for (i = 0; i < 8; i = i + 1) begin
            v = 8'($random(seed));
            e_pd = v[6];
            bus(1'b1, OFS_XCVR_CTRL, v);
            @(negedge clock_i);
            chk({suspended, dpd, dmd}, {v[7], v[6], v[6]});
            rdchk(OFS_XCVR_CTRL, v & 8'hc0);
            rdchk(OFS_OBSERVE, obs(1'b0, e_pd));
        end
        // Pull-up only in plain device mode, mirrored in observe register
        for (i = 0; i < 8; i = i + 1) begin
            v = 8'($random(seed));
            e_pu = (v[4] | i[2]) & !i[0] & !i[1];
            @(posedge clock_i);
            host_mode_i <= i[0];
            otg_mode_i  <= i[1];
            bus(1'b1, OFS_PULLUP, v | {3'h0, i[2], 4'h0});
            @(negedge clock_i);
            chk(pu, e_pu);
            rdchk(OFS_PULLUP, (v | {3'h0, i[2], 4'h0}) & 8'h10);
            rdchk(OFS_OBSERVE, obs(e_pu, e_pd));
        end
        // Resume wake: refused in host mode, taken in device mode
        bus(1'b1, OFS_XCVR_CTRL, 8'h80);
        bus(1'b1, OFS_EVT_MASK, 8'h03);
        @(posedge clock_i);
        host_mode_i <= 1'b1;
        otg_mode_i  <= 1'b0;
        bus(1'b1, OFS_WAKE_RST, 8'h60);
        k_req <= 1'b1;
        repeat (4) @(negedge clock_i);
        chk({wake, irq}, 2'b00);
        @(posedge clock_i);
        host_mode_i <= 1'b0;
        repeat (4) @(negedge clock_i);
        chk({wake, irq}, 2'b11);
        rdchk(OFS_WAKE_RST, 8'h61);
        rdchk(OFS_EVT_STAT, 8'h01);
        k_req <= 1'b0;
        bus(1'b1, OFS_WAKE_RST, 8'h40);
        repeat (3) @(negedge clock_i);
        chk({wake, irq}, 2'b00);
        rdchk(OFS_WAKE_RST, 8'h40);
        // Synchronous detect flag and masked event interrupt
        bus(1'b1, OFS_EVT_MASK, 8'h00);
        sync_irq_i <= 1'b1;
        repeat (3) @(negedge clock_i);
        chk(irq, 1'b0);
        rdchk(OFS_WAKE_RST, 8'h42);
        bus(1'b1, OFS_EVT_MASK, 8'h02);
        @(negedge clock_i);
        chk(irq, 1'b1);
        @(posedge clock_i);
        sync_irq_i <= 1'b0;
        rdchk(OFS_EVT_STAT, 8'h02);
        @(negedge clock_i);
        chk(irq, 1'b0);
        rdchk(OFS_WAKE_RST, 8'h42);
        rdchk(OFS_WAKE_RST, 8'h40);
        // Module soft reset: two-cycle pulse, bit reads zero, regs cleared
        bus(1'b1, OFS_XCVR_CTRL, 8'hc0);
        bus(1'b1, OFS_WAKE_RST, 8'hc0);
        @(negedge clock_i);
        chk({mrst, suspended}, 2'b11);
        @(negedge clock_i);
        chk({mrst, suspended}, 2'b10);
        @(negedge clock_i);
        chk(mrst, 1'b0);
        rdchk(OFS_WAKE_RST, 8'h00);
        rdchk(OFS_XCVR_CTRL, 8'h00);
        rdchk(9'h1fc, 8'h00);
        final_report();
    end
endmodule // tb_usb_transceiver_control_regs
